// ==== tsm_tap_top.v ====
/*
  Test access port: oversampled four-wire port, controller, instruction
  register, boundary, run-test control, bypass and identification registers,
  and a FIFO carrying each updated boundary word to core logic while it has room.
  Assumes the test clock is far slower than core_clk (at least 4 samples per
  half period) and that the opcode decoder outside answers in the same clock.
*/
`timescale 1ns/1ps
`include "tsm_defines.vh"
// What this block does
// - next state chosen from mode select at each test-clock rise only.
// - sixteen states, six stable, ten left after one cycle.
// - reset state after power-up; test logic held reset, normal function runs.
// - mode select held high returns to reset state within five clocks.
// - instruction forced to 10000001 at power-up and in reset state.
// - output-drive control boundary cells cleared to zero on reset.
// - run-test control register reset to 010.
// - selected run-test operation runs only while in run-test/idle.
// - scan select states do nothing and leave after one cycle.
// - selected data register, except run-test control, captures on the rise leaving capture-DR.
// - data out enabled on first fall in shift state, driving the lsb.
// - one bit shifts per rise after entry; last on the leaving rise.
// - data out returns to high impedance on first fall in exit1.
// - resuming shift from an exit state keeps shifted contents.
// - pause states do nothing and hold partial contents.
// - holding latches load from shift stage on fall in update-DR.
// - instruction shift stage captures 10000001 in capture-IR.
// - instruction latches load on fall in update-IR; takes effect then.
// - shift stage plus holding latches except bypass and identification.
// - eight-bit instruction; bit 7 is even parity over the opcode.
// - unimplemented opcodes behave as bypass.
// - only one register sits in the scan path at a time.
// - inputs sampled on rising edge, outputs change on falling edge.
// - 44-bit boundary, 3-bit run-test control, 1-bit bypass, 32-bit ident.
// - bypass register captures zero in capture-DR.
module tsm_tap_top #(
  parameter [`TSM_ID_W-1:0] ID_CODE = 32'h0000_0001, // arbitrary value, bit 0 set
  parameter                 DEPTH   = `TSM_FIFO_DEPTH,
  parameter                 CW      = `TSM_FIFO_CW
) (
  input  wire                  core_clk,      // 25 MHz block clock
  input  wire                  arst_n,        // power-up reset, active low
  input  wire                  tck,           // test clock pin
  input  wire                  tms,           // test mode select pin
  input  wire                  tdi,           // test data in pin
  output reg                   tdo_q,         // test data out pin
  output reg                   tdo_oe_q,      // drive enable for test data out
  output reg  [`TSM_IR_W-1:0]  instr_q,       // instruction holding latches
  output reg                   instr_par_ok_q,// holding latches carry even parity
  input  wire [1:0]            dr_sel,        // decoded data register select
  input  wire                  opcode_known,  // decoder recognises the opcode
  input  wire                  dr_update_en,  // instruction updates its register
  input  wire                  bsr_cap_pins,  // capture pins, else own latches
  input  wire [`TSM_BSR_W-1:0] bsr_pins,      // pin values for boundary capture
  output reg  [`TSM_BSR_W-1:0] bsr_hold_q,    // boundary holding latches
  output reg  [`TSM_RTC_W-1:0] rtc_hold_q,    // run-test control latches
  output reg                   run_test_q,    // selected operation may run
  output reg                   test_logic_rst_q, // controller in reset state
  output wire [3:0]            tap_state_q,   // controller state
  output wire                  upd_valid,     // updated boundary word waiting
  input  wire                  upd_ready,     // consumer takes the word
  output wire [`TSM_BSR_W-1:0] upd_data,      // updated boundary word
  output wire                  upd_room       // FIFO can take another word
);
  // pin synchronisers: first stage feeds only the second
  reg tck_s1_q;
  reg tck_s2_q;
  reg tck_s3_q;
  reg tms_s1_q;
  reg tms_s2_q;
  reg tdi_s1_q;
  reg tdi_s2_q;

  // shift stages
  reg [`TSM_IR_W-1:0]  ir_sh_q;
  reg [`TSM_BSR_W-1:0] bsr_sh_q;
  reg [`TSM_RTC_W-1:0] rtc_sh_q;
  reg                  byp_sh_q;
  reg [`TSM_ID_W-1:0]  id_sh_q;

  wire       tck_rise = tck_s2_q & ~tck_s3_q;
  wire       tck_fall = ~tck_s2_q & tck_s3_q;
  wire [3:0] st       = tap_state_q;
  wire [1:0] sel_eff;
  wire       in_tlr;
  wire       upd_push;

  // unknown opcodes and bad parity fall back to the one-bit path
  assign sel_eff = (opcode_known && instr_par_ok_q) ? dr_sel : `TSM_DR_BYP;
  assign in_tlr  = (st == `TSM_ST_TLR);

  // even parity over the whole byte, bit 7 included
  function par_even;
    input [`TSM_IR_W-1:0] v;
    begin
      par_even = ~(^v);
    end
  endfunction

  // lsb of whichever register is in the scan path
  function scan_lsb;
    input       ir_path;
    input [1:0] sel;
    input       ir0;
    input       bsr0;
    input       rtc0;
    input       byp0;
    input       id0;
    begin
      if (ir_path) begin
        scan_lsb = ir0;
      end else begin
        case (sel)
          `TSM_DR_BSR: scan_lsb = bsr0;
          `TSM_DR_RTC: scan_lsb = rtc0;
          `TSM_DR_ID:  scan_lsb = id0;
          default:     scan_lsb = byp0;
        endcase
      end
    end
  endfunction

  // two flops on every pin before any logic sees it
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
      tms_s1_q <= 1'b1;
      tms_s2_q <= 1'b1;
      tdi_s1_q <= 1'b1;
      tdi_s2_q <= 1'b1;
    end else begin
      tck_s1_q <= tck;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      tms_s1_q <= tms;
      tms_s2_q <= tms_s1_q;
      tdi_s1_q <= tdi;
      tdi_s2_q <= tdi_s1_q;
    end
  end

  tsm_tap_fsm u_fsm (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .step     (tck_rise),
    .tms      (tms_s2_q),
    .state_q  (tap_state_q)
  );

  // instruction path: capture and shift act on the rise; pause holds
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_sh_q <= `TSM_IR_RST;
    end else if (tck_rise) begin
      case (st)
        `TSM_ST_CAPIR: ir_sh_q <= `TSM_IR_CAPT;
        `TSM_ST_SHIR:  ir_sh_q <= {tdi_s2_q, ir_sh_q[`TSM_IR_W-1:1]};
        default:       ir_sh_q <= ir_sh_q;
      endcase
    end
  end

  // instruction latches: loaded on the fall in update, forced in reset state
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_q        <= `TSM_IR_RST;
      instr_par_ok_q <= 1'b1;
    end else if (in_tlr) begin
      instr_q        <= `TSM_IR_RST;
      instr_par_ok_q <= 1'b1;
    end else if (tck_fall && (st == `TSM_ST_UPIR)) begin
      instr_q        <= ir_sh_q;
      instr_par_ok_q <= par_even(ir_sh_q);
    end
  end

  // boundary shift stage; only the selected register moves
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bsr_sh_q <= {`TSM_BSR_W{1'b0}};
    end else if (tck_rise && (sel_eff == `TSM_DR_BSR)) begin
      if (st == `TSM_ST_CAPDR) begin
        bsr_sh_q <= bsr_cap_pins ? bsr_pins : bsr_hold_q;
      end else if (st == `TSM_ST_SHDR) begin
        bsr_sh_q <= {tdi_s2_q, bsr_sh_q[`TSM_BSR_W-1:1]};
      end
    end
  end

  // run-test control shift stage keeps its value through capture
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rtc_sh_q <= `TSM_RTC_RST;
    end else if (tck_rise && (sel_eff == `TSM_DR_RTC) && (st == `TSM_ST_SHDR)) begin
      rtc_sh_q <= {tdi_s2_q, rtc_sh_q[`TSM_RTC_W-1:1]};
    end
  end

  // bypass and identification: shift stage only, no latches
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      byp_sh_q <= `TSM_BYP_CAPT;
      id_sh_q  <= ID_CODE;
    end else if (tck_rise) begin
      if ((sel_eff == `TSM_DR_BYP) && (st == `TSM_ST_CAPDR)) begin
        byp_sh_q <= `TSM_BYP_CAPT;
      end else if ((sel_eff == `TSM_DR_BYP) && (st == `TSM_ST_SHDR)) begin
        byp_sh_q <= tdi_s2_q;
      end
      if ((sel_eff == `TSM_DR_ID) && (st == `TSM_ST_CAPDR)) begin
        id_sh_q <= ID_CODE;
      end else if ((sel_eff == `TSM_DR_ID) && (st == `TSM_ST_SHDR)) begin
        id_sh_q <= {tdi_s2_q, id_sh_q[`TSM_ID_W-1:1]};
      end
    end
  end

  // boundary latches; reset state clears only the drive-control cells
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bsr_hold_q <= {`TSM_BSR_W{1'b0}};
    end else if (in_tlr) begin
      bsr_hold_q[`TSM_OE_HI:`TSM_OE_LO] <= `TSM_OE_RST;
    end else if (tck_fall && (st == `TSM_ST_UPDR) && dr_update_en
                 && (sel_eff == `TSM_DR_BSR)) begin
      bsr_hold_q <= bsr_sh_q;
    end
  end

  // run-test control latches; default operation is signature analysis
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rtc_hold_q <= `TSM_RTC_RST;
    end else if (in_tlr) begin
      rtc_hold_q <= `TSM_RTC_RST;
    end else if (tck_fall && (st == `TSM_ST_UPDR) && dr_update_en
                 && (sel_eff == `TSM_DR_RTC)) begin
      rtc_hold_q <= rtc_sh_q;
    end
  end

  // data out changes only on the fall; enabled only in shift states
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_q <= (st == `TSM_ST_SHDR) || (st == `TSM_ST_SHIR);
      tdo_q    <= scan_lsb(st == `TSM_ST_SHIR, sel_eff, ir_sh_q[0], bsr_sh_q[0],
                           rtc_sh_q[0], byp_sh_q, id_sh_q[0]);
    end
  end

  // operation runs only while idling; leaving reset always passes here first
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_test_q       <= 1'b0;
      test_logic_rst_q <= 1'b1;
    end else begin
      run_test_q       <= (st == `TSM_ST_RTI);
      test_logic_rst_q <= in_tlr;
    end
  end

  // each boundary update is handed to core logic; a full FIFO drops the word
  assign upd_push = tck_fall && (st == `TSM_ST_UPDR) && dr_update_en
                    && (sel_eff == `TSM_DR_BSR);

  tsm_fifo #(
    .W     (`TSM_BSR_W),
    .DEPTH (DEPTH),
    .CW    (CW)
  ) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (upd_push),
    .in_ready  (upd_room),
    .in_data   (bsr_sh_q),
    .out_valid (upd_valid),
    .out_ready (upd_ready),
    .out_data  (upd_data)
  );
endmodule

// ==== tsm_defines.vh ====
/*
  Shared constants of the test access port block: controller state codes,
  register widths, reset and capture values, data register select codes.
  Assumes it is included by its bare name from every design file that uses it.
*/
`ifndef TSM_DEFINES_VH
`define TSM_DEFINES_VH

// controller state codes
`define TSM_ST_TLR    4'h0
`define TSM_ST_RTI    4'h1
`define TSM_ST_SELDR  4'h2
`define TSM_ST_CAPDR  4'h3
`define TSM_ST_SHDR   4'h4
`define TSM_ST_EX1DR  4'h5
`define TSM_ST_PDR    4'h6
`define TSM_ST_EX2DR  4'h7
`define TSM_ST_UPDR   4'h8
`define TSM_ST_SELIR  4'h9
`define TSM_ST_CAPIR  4'ha
`define TSM_ST_SHIR   4'hb
`define TSM_ST_EX1IR  4'hc
`define TSM_ST_PIR    4'hd
`define TSM_ST_EX2IR  4'he
`define TSM_ST_UPIR   4'hf

// register widths and fixed values
`define TSM_IR_W      8
`define TSM_IR_RST    8'h81
`define TSM_IR_CAPT   8'h81
`define TSM_IR_PAR    7
`define TSM_BSR_W     44
`define TSM_OE_HI     43
`define TSM_OE_LO     40
`define TSM_OE_RST    4'h0
`define TSM_RTC_W     3
`define TSM_RTC_RST   3'h2
`define TSM_ID_W      32
`define TSM_BYP_CAPT  1'h0

// data register select codes
`define TSM_DR_BSR    2'h0
`define TSM_DR_RTC    2'h1
`define TSM_DR_BYP    2'h2
`define TSM_DR_ID     2'h3

`define TSM_FIFO_DEPTH 16
`define TSM_FIFO_CW    5

`endif

// ==== tsm_fifo.v ====
/*
  Shift-style FIFO for updated boundary words; entry 0 is always the head.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module tsm_fifo #(
  parameter W     = 44,
  parameter DEPTH = 16,
  parameter CW    = 5
) (
  input  wire         core_clk,  // block clock
  input  wire         arst_n,    // async reset, active low
  input  wire         in_valid,  // write request
  output reg          in_ready,  // room for one more word
  input  wire [W-1:0] in_data,   // word to store
  output reg          out_valid, // head word present
  input  wire         out_ready, // consumer takes head
  output wire [W-1:0] out_data   // head word
);
  reg  [W-1:0]  mem [0:DEPTH-1];
  reg  [CW-1:0] count_q;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;
  wire [CW-1:0] count_d = count_q + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
  wire [CW-1:0] wr_idx  = pop ? count_q - {{(CW-1){1'b0}}, 1'b1} : count_q;
  integer i;

  assign out_data = mem[0];

  // flags are registered so both ready and valid come straight from flops
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q   <= {CW{1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count_q   <= count_d;
      in_ready  <= (count_d != DEPTH[CW-1:0]);
      out_valid <= (count_d != {CW{1'b0}});
    end
  end

  // storage moves one place toward the head on every pop
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {W{1'b0}};
      end
    end else begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (push && (i == wr_idx)) begin
          mem[i] <= in_data;
        end else if (pop && (i < DEPTH - 1)) begin
          mem[i] <= mem[i + 1];
        end
      end
    end
  end
endmodule

// ==== tsm_tap_fsm.v ====
/*
  Sixteen-state test access port controller.
  Assumes step pulses once per rising test-clock edge and tms is synchronised.
*/
`timescale 1ns/1ps
`include "tsm_defines.vh"
module tsm_tap_fsm (
  input  wire       core_clk, // block clock
  input  wire       arst_n,   // async reset, active low
  input  wire       step,     // one-cycle pulse per test-clock rise
  input  wire       tms,      // mode select level at that rise
  output reg  [3:0] state_q   // current controller state
);
  localparam [3:0] ST_TLR = `TSM_ST_TLR;

  // transition table; only the select states branch between the two paths
  function [3:0] next_state;
    input [3:0] s;
    input       m;
    begin
      case (s)
        `TSM_ST_TLR:   next_state = m ? `TSM_ST_TLR   : `TSM_ST_RTI;
        `TSM_ST_RTI:   next_state = m ? `TSM_ST_SELDR : `TSM_ST_RTI;
        `TSM_ST_SELDR: next_state = m ? `TSM_ST_SELIR : `TSM_ST_CAPDR;
        `TSM_ST_CAPDR: next_state = m ? `TSM_ST_EX1DR : `TSM_ST_SHDR;
        `TSM_ST_SHDR:  next_state = m ? `TSM_ST_EX1DR : `TSM_ST_SHDR;
        `TSM_ST_EX1DR: next_state = m ? `TSM_ST_UPDR  : `TSM_ST_PDR;
        `TSM_ST_PDR:   next_state = m ? `TSM_ST_EX2DR : `TSM_ST_PDR;
        `TSM_ST_EX2DR: next_state = m ? `TSM_ST_UPDR  : `TSM_ST_SHDR;
        `TSM_ST_UPDR:  next_state = m ? `TSM_ST_SELDR : `TSM_ST_RTI;
        `TSM_ST_SELIR: next_state = m ? `TSM_ST_TLR   : `TSM_ST_CAPIR;
        `TSM_ST_CAPIR: next_state = m ? `TSM_ST_EX1IR : `TSM_ST_SHIR;
        `TSM_ST_SHIR:  next_state = m ? `TSM_ST_EX1IR : `TSM_ST_SHIR;
        `TSM_ST_EX1IR: next_state = m ? `TSM_ST_UPIR  : `TSM_ST_PIR;
        `TSM_ST_PIR:   next_state = m ? `TSM_ST_EX2IR : `TSM_ST_PIR;
        `TSM_ST_EX2IR: next_state = m ? `TSM_ST_UPIR  : `TSM_ST_SHIR;
        `TSM_ST_UPIR:  next_state = m ? `TSM_ST_SELDR : `TSM_ST_RTI;
        default:       next_state = `TSM_ST_TLR;
      endcase
    end
  endfunction

  // state moves only on a test-clock rise; tms high walks home in five steps
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_TLR;
    end else if (step) begin
      state_q <= next_state(state_q, tms);
    end
  end
endmodule

// ==== tsm_tap_monitor.sv ====
/*
  Checker on the test access port top ports: controller stepping, data-out
  timing, reset-state values, run-test level and update FIFO flags.
  Assumes tck is far slower than core_clk; bound onto tsm_tap_top.
*/
`timescale 1ns/1ps
`include "tsm_defines.vh"
module tsm_tap_monitor (
  input wire        core_clk,         // block clock
  input wire        arst_n,           // async reset, active low
  input wire        tck,              // test clock pin
  input wire        tdo_q,            // data out
  input wire        tdo_oe_q,         // data out enable
  input wire [7:0]  instr_q,          // instruction latches
  input wire [43:0] bsr_hold_q,       // boundary latches
  input wire [2:0]  rtc_hold_q,       // run-test control latches
  input wire        run_test_q,       // operation may run
  input wire        test_logic_rst_q, // in reset state
  input wire [3:0]  tap_state_q,      // controller state
  input wire        upd_valid,        // FIFO head valid
  input wire        upd_ready,        // consumer takes head
  input wire        upd_room          // FIFO not full
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // tck seen two samples back tells which edge launched the change
  a_state_on_rise: assert property ($changed(tap_state_q) |-> $past(tck, 2))
    else $error("state changed away from a test-clock rise");
  a_tdo_on_fall: assert property ($changed(tdo_q) |-> !$past(tck, 2))
    else $error("data out changed away from a test-clock fall");
  // the ten transient states last one test-clock period, 8 core cycles here
  a_transient_left: assert property ($changed(tap_state_q) && !(tap_state_q inside
    {`TSM_ST_TLR, `TSM_ST_RTI, `TSM_ST_SHDR, `TSM_ST_PDR, `TSM_ST_SHIR, `TSM_ST_PIR})
    |-> ##[1:12] $changed(tap_state_q))
    else $error("transient state held too long");
  a_select_pass: assert property ($changed(tap_state_q) &&
    $past(tap_state_q) == `TSM_ST_SELDR |-> tap_state_q inside {`TSM_ST_CAPDR, `TSM_ST_SELIR})
    else $error("bad exit from data select state");
  a_reset_values: assert property ((tap_state_q == `TSM_ST_TLR) [*2] |->
    instr_q == `TSM_IR_RST && rtc_hold_q == `TSM_RTC_RST && bsr_hold_q[43:40] == 4'h0)
    else $error("reset state values not forced");
  a_reset_flag: assert property ((tap_state_q == `TSM_ST_TLR) [*2] |-> test_logic_rst_q)
    else $error("reset state flag low");
  a_run_in_idle: assert property (run_test_q == ($past(tap_state_q) == `TSM_ST_RTI))
    else $error("run level differs from idle state");
  a_oe_rise: assert property ($rose(tdo_oe_q) |->
    tap_state_q inside {`TSM_ST_SHDR, `TSM_ST_SHIR})
    else $error("data out enabled outside shift");
  a_oe_fall: assert property ($fell(tdo_oe_q) |->
    tap_state_q inside {`TSM_ST_EX1DR, `TSM_ST_EX1IR})
    else $error("data out released outside exit1");
  a_pop_only: assert property ($fell(upd_valid) |-> $past(upd_ready))
    else $error("FIFO head vanished without a pop");
  a_full_valid: assert property (!upd_room |-> upd_valid)
    else $error("FIFO full but empty");
  c_pause: cover property (tap_state_q == `TSM_ST_PDR);
  c_full: cover property (!upd_room);
  c_run: cover property (run_test_q);
endmodule
bind tsm_tap_top tsm_tap_monitor u_mon (
  .core_clk, .arst_n, .tck, .tdo_q, .tdo_oe_q, .instr_q, .bsr_hold_q, .rtc_hold_q,
  .run_test_q, .test_logic_rst_q, .tap_state_q, .upd_valid, .upd_ready, .upd_room
);

// ==== tsm_jtag_host.sv ====
/*
  Model of the outside test controller driving the four-wire port.
  Assumes a 320 ns test clock that stands still between calls.
*/
`timescale 1ns/1ps
module tsm_jtag_host (
  output reg  tck,   // test clock
  output reg  tms,   // mode select, pulled up
  output reg  tdi,   // data in, pulled up
  input  wire tdo,   // data out
  input  wire tdo_oe // data out enable
);
  reg so;    // data out seen before last rise
  reg oe;    // enable seen before last rise
  reg oe_ok; // enable behaved through last scan
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // levels change on the fall, so they are steady at the rise
  task step(input m, input d);
    begin
      tms = m;
      tdi = d;
      #160;
      so = tdo_oe ? tdo : ~tdo; // a released pin must not pass for data
      oe = tdo_oe;
      tck = 1'b1;
      #160;
      tck = 1'b0;
    end
  endtask
  // scan from idle, lsb first; optional pause after bit p-1
  task scan(input ir, input integer n, input [63:0] din, input integer p,
            output [63:0] dout);
    integer i;
    integer j;
    begin
      oe_ok = 1'b1;
      dout = 64'h0;
      step(1'b1, 1'b1);
      if (ir) step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      step(1'b0, 1'b1); // entry to shift, no shift yet
      for (i = 0; i < n; i = i + 1) begin
        step(i == n - 1 || i == p - 1, din[i]);
        dout[i] = so;
        if (!oe) oe_ok = 1'b0;
        if (i == p - 1) begin
          // pause, pause, exit2, shift; data out must stay released
          for (j = 0; j < 4; j = j + 1) begin
            step(j == 2, 1'b1);
            if (oe) oe_ok = 1'b0;
          end
        end
      end
      step(1'b1, 1'b1);
      if (oe) oe_ok = 1'b0;
      step(1'b0, 1'b1); // scans end in idle
    end
  endtask
endmodule

// ==== test_tap_state_machine_and_ir.sv ====
/*
  Self-checking bench for the test access port top with a host model.
  Assumes the external opcode decoder is replaced by bench-driven selects.
*/
`timescale 1ns/1ps
`include "tsm_defines.vh"
module test_tap_state_machine_and_ir;
  localparam [31:0] IDV = 32'h5a5a_0c35; // arbitrary value, bit 0 set
  reg         core_clk, arst_n, upd_ready, opcode_known, dr_update_en, bsr_cap_pins;
  reg  [1:0]  dr_sel;
  reg  [43:0] bsr_pins;
  wire        tck, tms, tdi, tdo, oe, par_ok, run, tlr, uv, room;
  wire [7:0]  instr;
  wire [43:0] hold, ud;
  wire [2:0]  rtc;
  wire [3:0]  st;
  reg  [63:0] d;
  integer     mismatches, n_compared, i;
  tsm_jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(oe));
  tsm_tap_top #(.ID_CODE(IDV)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_q(tdo), .tdo_oe_q(oe), .instr_q(instr), .instr_par_ok_q(par_ok),
    .dr_sel(dr_sel), .opcode_known(opcode_known), .dr_update_en(dr_update_en),
    .bsr_cap_pins(bsr_cap_pins), .bsr_pins(bsr_pins), .bsr_hold_q(hold),
    .rtc_hold_q(rtc), .run_test_q(run), .test_logic_rst_q(tlr), .tap_state_q(st),
    .upd_valid(uv), .upd_ready(upd_ready), .upd_data(ud), .upd_room(room));
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // let edge updates land before looking
  task settle;
    begin
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask
  task t_reset;
    begin
      chk(instr, `TSM_IR_RST);
      chk(rtc, `TSM_RTC_RST);
      chk(hold[`TSM_OE_HI:`TSM_OE_LO], `TSM_OE_RST);
      chk({st, tlr}, {`TSM_ST_TLR, 1'b1});
      chk({uv, room, oe, run}, 4'h4);
      $display("t_reset done");
    end
  endtask
  task t_ir;
    begin
      u_host.step(1'b0, 1'b1);
      settle;
      chk({st, run}, {`TSM_ST_RTI, 1'b1});
      u_host.scan(1'b1, 8, 64'h03, 0, d);
      settle;
      chk(d[7:0], `TSM_IR_CAPT);
      chk(u_host.oe_ok, 1'b1);
      chk({instr, par_ok}, {8'h03, 1'b1});
      $display("t_ir done");
    end
  endtask
  // bypass chosen directly, then by an unknown opcode
  task t_byp;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        @(posedge core_clk);
        dr_sel <= i ? `TSM_DR_ID : `TSM_DR_BYP;
        opcode_known <= !i;
        #1;
        u_host.scan(1'b0, 8, 64'ha5, 0, d);
        chk(d[7:0], 8'h4a);
      end
      $display("t_byp done");
    end
  endtask
  task t_id;
    begin
      @(posedge core_clk);
      opcode_known <= 1'b1;
      #1;
      u_host.scan(1'b0, 32, 64'h0, 10, d);
      chk(d[31:0], IDV);
      $display("t_id done");
    end
  endtask
  task t_bsr;
    begin
      @(posedge core_clk);
      dr_sel <= `TSM_DR_BSR;
      dr_update_en <= 1'b1;
      bsr_pins <= 44'h123_4567_89ab;
      #1;
      u_host.scan(1'b0, 44, 64'hfed_cba9_8765, 20, d);
      settle;
      chk(d[43:0], 44'h123_4567_89ab);
      chk(hold, 44'hfed_cba9_8765);
      chk({uv, ud}, {1'b1, 44'hfed_cba9_8765});
      @(posedge core_clk);
      upd_ready <= 1'b1;
      @(posedge core_clk);
      upd_ready <= 1'b0;
      settle;
      chk(uv, 1'b0);
      $display("t_bsr done");
    end
  endtask
  // seventeen captures with no consumer, the last one dropped
  task t_fifo;
    begin
      for (i = 0; i < 17; i = i + 1) begin
        @(posedge core_clk);
        bsr_pins <= i;
        #1;
        u_host.step(1'b1, 1'b1);
        u_host.step(1'b0, 1'b1);
        u_host.step(1'b1, 1'b1);
        u_host.step(1'b1, 1'b1);
        u_host.step(1'b0, 1'b1);
        settle;
        chk(room, i < 15);
      end
      chk(hold, 44'h10);
      for (i = 0; i < 16; i = i + 1) begin
        @(negedge core_clk);
        chk({uv, ud}, {1'b1, 44'h0 + i});
        @(posedge core_clk);
        upd_ready <= 1'b1;
        @(posedge core_clk);
        upd_ready <= 1'b0;
      end
      settle;
      chk({uv, room}, 2'h1);
      $display("t_fifo done");
    end
  endtask
  // boundary captures its own latches instead of the pins
  task t_cap;
    begin
      @(posedge core_clk);
      bsr_cap_pins <= 1'b0;
      #1;
      u_host.scan(1'b0, 44, 64'h0, 0, d);
      settle;
      chk(d[43:0], 44'h10);
      chk(hold, 44'h0);
      $display("t_cap done");
    end
  endtask
  // run-test control update, then five mode-select highs from shift
  task t_rtc;
    begin
      @(posedge core_clk);
      dr_sel <= `TSM_DR_RTC;
      #1;
      u_host.scan(1'b0, 3, 64'h5, 0, d);
      settle;
      chk({d[2:0], rtc}, 6'h15);
      @(posedge core_clk);
      dr_update_en <= 1'b0;
      #1;
      u_host.step(1'b1, 1'b1);
      u_host.step(1'b0, 1'b1);
      u_host.step(1'b0, 1'b1);
      repeat (5) u_host.step(1'b1, 1'b1);
      settle;
      chk({st, instr, rtc}, {`TSM_ST_TLR, `TSM_IR_RST, `TSM_RTC_RST});
      $display("t_rtc done");
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // the whole run takes well under 10000 cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    arst_n = 1'b0;
    upd_ready = 1'b0;
    opcode_known = 1'b1;
    dr_update_en = 1'b0;
    bsr_cap_pins = 1'b1;
    dr_sel = `TSM_DR_BYP;
    bsr_pins = 44'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    settle;
    t_reset;
    t_ir;
    t_byp;
    t_id;
    t_bsr;
    t_fifo;
    t_cap;
    t_rtc;
    close_out;
  end
endmodule
